//--- tb/bcs_charger_model.sv
// behavioural charging circuit feeding samples to the sequencer
// assumes the bench sets cell voltage, temperature and presence
`timescale 1ns/1ps
module bcs_charger_model (
  // clock
  input wire clk,
  // controls from the sequencer
  input wire charge_en,
  input wire target_4v1,
  input wire [15:0] charge_ma_set,
  // bench settings
  input wire [15:0] set_mv,
  input wire [15:0] set_temp,
  input wire set_present,
  // samples
  output reg [15:0] bat_mv,
  output reg [15:0] chg_ma,
  output reg [15:0] cpu_temp,
  output reg bat_present
);
  // no cell reads as zero volts rather than a stale value
  always @(posedge clk) begin
    cpu_temp <= set_temp;
    bat_present <= set_present;
    chg_ma <= charge_en ? charge_ma_set : 16'h0000;
    if (!set_present) begin
      bat_mv <= 16'h0000;
    end else if (!charge_en) begin
      bat_mv <= set_mv;
    end else if (bat_mv < (target_4v1 ? 16'h1004 : 16'h1068)) begin
      bat_mv <= bat_mv + 16'h0001;
    end
  end
endmodule // bcs_charger_model

//--- tb/bcs_seq_props.sv
// port checker for the backup battery charge sequencer
// assumes one clock domain and srst synchronous, active high
`timescale 1ns/1ps
module bcs_seq_props (
  // clock and reset
  input wire clk,
  input wire srst,
  // apb status
  input wire pready,
  input wire pslverr,
  // charger samples
  input wire [15:0] bat_mv,
  input wire [15:0] cpu_temp,
  input wire bat_present,
  input wire main_power_ok,
  // controls
  input wire charge_en,
  input wire target_4v1,
  input wire [15:0] charge_ma_set,
  input wire save_to_flash,
  input wire ram_retain,
  input wire irq
);
  reg [3:0] flt_cnt;
  reg [3:0] tmp_cnt;
  reg [15:0] up_cnt;
  wire signed [15:0] bat_t = $signed(cpu_temp) - 16'sh001E;
  wire bad_t = (bat_t > 16'sh003C) || (bat_t < 16'sh0000);
  // saturating counts; sync lag hidden by waiting for a full count
  always @(posedge clk) begin
    flt_cnt <= (srst || (bat_present && bat_mv >= 16'h09C4)) ? 4'h0 : flt_cnt + {3'h0, flt_cnt != 4'hF};
    tmp_cnt <= (srst || !bad_t) ? 4'h0 : tmp_cnt + {3'h0, tmp_cnt != 4'hF};
    up_cnt <= srst ? 16'h0000 : up_cnt + {15'h0, up_cnt != 16'hFFFF};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wait_nocharge_a: assert property (up_cnt < 16'hFFFF |-> !charge_en)
    else $error("charger on during power-up wait");
  restart_off_a: assert property ($fell(srst) |-> !charge_en && !target_4v1)
    else $error("charge controls not cleared by power-up");
  fault_off_a: assert property (flt_cnt == 4'hF |-> !charge_en)
    else $error("charging with missing or flat battery");
  temp_off_a: assert property (tmp_cnt == 4'hF |-> !charge_en)
    else $error("charging outside temperature limits");
  hot_target_a: assert property (charge_en && target_4v1 |-> charge_ma_set == 16'h0014)
    else $error("hot target without slow current");
  mode_current_a: assert property (charge_en |-> charge_ma_set inside {16'h0064, 16'h0014})
    else $error("charge current not a mode value");
  save_window_a: assert property ($fell(main_power_ok) |-> ##[1:6] save_to_flash)
    else $error("no save after power loss");
  ram_keep_a: assert property (main_power_ok [*6] |-> ram_retain)
    else $error("ram retention dropped with power present");
  cover property (irq);
  cover property ($rose(save_to_flash));
  cover property (pslverr && pready);
endmodule // bcs_seq_props

bind bcs_seq bcs_seq_props u_props (.clk(clk), .srst(srst), .pready(pready), .pslverr(pslverr),
  .bat_mv(bat_mv), .cpu_temp(cpu_temp), .bat_present(bat_present), .main_power_ok(main_power_ok),
  .charge_en(charge_en), .target_4v1(target_4v1), .charge_ma_set(charge_ma_set),
  .save_to_flash(save_to_flash), .ram_retain(ram_retain), .irq(irq));

//--- tb/bcs_seq_tb.sv
// self-checking bench for the charge sequencer over apb
// assumes a 250 MHz clock; two-minute timers are never reached
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_seq_tb;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [15:0] set_mv = 16'h0F00;
  reg [15:0] set_temp = 16'h0037;
  reg set_present = 1'b1;
  reg main_power_ok = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, charge_en, target_4v1, bat_present, save_to_flash, ram_retain, irq;
  wire [15:0] bat_mv, chg_ma, cpu_temp, charge_ma_set;
  reg [31:0] rd;
  reg err;
  integer fail_count = 0;
  integer n_compared = 0;

  always #2 clk = ~clk;

  bcs_seq dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bat_mv(bat_mv), .chg_ma(chg_ma),
    .cpu_temp(cpu_temp), .bat_present(bat_present), .main_power_ok(main_power_ok), .charge_en(charge_en),
    .target_4v1(target_4v1), .charge_ma_set(charge_ma_set), .save_to_flash(save_to_flash),
    .ram_retain(ram_retain), .irq(irq));

  bcs_charger_model u_chg (.clk(clk), .charge_en(charge_en), .target_4v1(target_4v1),
    .charge_ma_set(charge_ma_set), .set_mv(set_mv), .set_temp(set_temp), .set_present(set_present),
    .bat_mv(bat_mv), .chg_ma(chg_ma), .cpu_temp(cpu_temp), .bat_present(bat_present));

  task chk(input [31:0] got, input [31:0] exp, input string msg);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        fail_count = fail_count + 1;
      end
    end
  endtask

  // one apb transfer; request held until pready is seen high or 50 extra cycles pass
  task apb(input reg wr, input [11:0] a, input [31:0] wd);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      if (pready !== 1'b1)
        fail_count = fail_count + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp, "register read");
    end
  endtask

  task reset_dut;
    begin
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
    end
  endtask

  task finish_test;
    begin
      $display("TB: compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    fail_count = fail_count + 1;
    finish_test;
  end

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(`BCS_A_STATE, 32'h0000000B);
    rdc(`BCS_A_TEMP, 32'h00000037);
    chk(charge_en, 1'b0, "charger on while waiting");
    chk(target_4v1, 1'b0, "hot target while waiting");
    rdc(`BCS_A_CTRL, 32'h00000014);
    rdc(`BCS_A_VOLT, 32'h00000F00);
    rdc(`BCS_A_CURR, 32'h00000000);
    apb(1'b1, `BCS_A_STATE, 32'h00000005);
    rdc(`BCS_A_STATE, 32'h0000000B);
    apb(1'b1, `BCS_A_IMASK, 32'h0000000F);
    rdc(`BCS_A_IMASK, 32'h0000000F);
    apb(1'b1, `BCS_A_SAVE, 32'hA5A51234);
    rdc(`BCS_A_SAVE, 32'hA5A51234);
    rdc(12'h040, 32'h00000000);
    chk(err, 1'b1, "unmapped error");
    // too hot during the wait must not leave the wait
    set_temp <= 16'h005B;
    repeat (20) @(posedge clk);
    rdc(`BCS_A_STATE, 32'h0000000B);
    rdc(`BCS_A_TEMP, 32'h0000005B);
    set_temp <= 16'h0037;
    // missing battery, then refitted without a power cycle
    set_present <= 1'b0;
    repeat (20) @(posedge clk);
    rdc(`BCS_A_STATE, 32'h00000007);
    rdc(`BCS_A_FLAGS, 32'h00000003);
    rdc(`BCS_A_ISTAT, 32'h00000003);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, `BCS_A_IMASK, 32'h00000000);
    @(negedge clk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `BCS_A_ISTAT, 32'h00000003);
    rdc(`BCS_A_ISTAT, 32'h00000000);
    apb(1'b1, `BCS_A_IMASK, 32'h0000000F);
    set_present <= 1'b1;
    repeat (20) @(posedge clk);
    rdc(`BCS_A_STATE, 32'h00000007);
    reset_dut;
    rdc(`BCS_A_STATE, 32'h0000000B);
    rdc(`BCS_A_FLAGS, 32'h00000000);
    // low-voltage limit at and just below 2.5 V
    set_mv <= 16'h09C4;
    repeat (20) @(posedge clk);
    rdc(`BCS_A_STATE, 32'h0000000B);
    set_mv <= 16'h09C3;
    repeat (20) @(posedge clk);
    rdc(`BCS_A_STATE, 32'h0000000A);
    set_mv <= 16'h0F00;
    repeat (6) @(posedge clk);
    reset_dut;
    rdc(`BCS_A_STATE, 32'h0000000B);
    // loss of main power opens the save window
    main_power_ok <= 1'b0;
    repeat (8) @(posedge clk);
    chk(save_to_flash, 1'b1, "save window");
    chk(ram_retain, 1'b0, "ram retain off");
    rdc(`BCS_A_FLAGS, 32'h00000004);
    main_power_ok <= 1'b1;
    repeat (8) @(posedge clk);
    chk(ram_retain, 1'b1, "ram retain on");
    finish_test;
  end
endmodule // bcs_seq_tb

//--- verilog/bcs_consts.vh
// constants for the backup battery charge sequencer
// assumes a 250 MHz system clock and millivolt / degree sample units
`ifndef BCS_CONSTS_VH
`define BCS_CONSTS_VH
// clock and time base
`define BCS_CLK_HZ 250000000
`define BCS_TICK_W 28
`define BCS_TICK_CYC 28'hEE6B27F
// times in seconds
`define BCS_WAIT_S 18'h00078
`define BCS_PAUSE_S 18'h0012C
`define BCS_NORM_LIMIT_S 18'h07080
`define BCS_SLOW_LIMIT_S 18'h23280
`define BCS_SEC_W 18
// voltages in mV
`define BCS_MV_FULL_HI 16'h1068
`define BCS_MV_FULL_LO 16'h1004
`define BCS_MV_RECHG 16'h0FA0
`define BCS_MV_MIN 16'h09C4
// temperatures in degrees C, signed 16 bit
`define BCS_T_OFFSET 16'h001E
`define BCS_T_HOT_MAX 16'h003C
`define BCS_T_NORM_MAX 16'h002D
`define BCS_T_COLD_MAX 16'h000A
// charge currents in mA
`define BCS_I_FAST 16'h0064
`define BCS_I_SLOW 16'h0014
// charge state codes
`define BCS_ST_FULL42 4'h0
`define BCS_ST_NORMAL 4'h1
`define BCS_ST_HOT 4'h2
`define BCS_ST_NOCHG 4'h3
`define BCS_ST_TOOHOT 4'h4
`define BCS_ST_COLD 4'h5
`define BCS_ST_TOOCOLD 4'h6
`define BCS_ST_NOBAT 4'h7
`define BCS_ST_FULL41 4'h8
`define BCS_ST_LOWV 4'hA
`define BCS_ST_WAIT 4'hB
`define BCS_ST_WAITDIS 4'hC
// register byte offsets
`define BCS_A_STATE 12'h000
`define BCS_A_TEMP 12'h004
`define BCS_A_VOLT 12'h008
`define BCS_A_CURR 12'h00C
`define BCS_A_FLAGS 12'h010
`define BCS_A_CTRL 12'h014
`define BCS_A_ISTAT 12'h018
`define BCS_A_IMASK 12'h01C
`define BCS_A_SAVE 12'h020
// flag bits
`define BCS_F_FAULT 0
`define BCS_F_SELFTEST 1
`define BCS_F_SAVING 2
`define BCS_F_SAVED 3
// interrupt events
`define BCS_IRQ_W 4
`define BCS_I_STATE 0
`define BCS_I_FAULT 1
`define BCS_I_FULL 2
`define BCS_I_SAVED 3
// power loss save window: 1/10 s in ms
`define BCS_SAVE_MS 18'h00064
`define BCS_MS_CYC 18'h3D090
`endif

//--- verilog/bcs_seq.v
// backup battery charge sequencer with APB status registers
// assumes charger samples come from pins of another domain; srst marks power-up
//
// Functional notes
// - power-up enters waiting state 11 two minutes
// - after wait, charge by temperature regardless
// - no charging outside hot or cold limits
// - target 4.2V normal/cold, 4.1V hot
// - full 4.2V shows 0, then wait-discharge 4.0V
// - power-up abandons cycle, restarts waiting
// - hot full 4.1V held until normal/cold
// - missing or under 2.5V: fault, self-test fails
// - charge timeout 8/40h pauses 5 minutes
// - battery temperature is cpu minus 30
// - cpu temperature readable by software
// - power loss: save retentive data within 100ms
// - with main power, data stays in RAM
// - fast recharge completes within eight hours
// - charge state readable as numeric code
// - mode bands: 11-45 normal, 46-60 hot, 0-10 cold
// - fault at power-up blocks charging until repower
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_seq (
  // clock and reset
  input wire clk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // charger samples, asynchronous pins
  input wire [15:0] bat_mv,
  input wire [15:0] chg_ma,
  input wire [15:0] cpu_temp,
  input wire bat_present,
  input wire main_power_ok,
  // charger controls
  output reg charge_en,
  output reg target_4v1,
  output reg [15:0] charge_ma_set,
  // retention store controls
  output reg save_to_flash,
  output reg ram_retain,
  // interrupt
  output wire irq
);
  wire sec_pulse;
  // synchronisers, two stages each
  reg [15:0] mv_s1_reg, mv_s2_reg, ma_s1_reg, ma_s2_reg, tc_s1_reg, tc_s2_reg;
  reg [1:0] pres_s_reg, pwr_s_reg;
  reg [1:0] fill_reg;
  reg [3:0] state_reg, state_next;
  reg [`BCS_SEC_W-1:0] secs_reg;
  reg [`BCS_SEC_W-1:0] ms_reg;
  reg [17:0] mscyc_reg;
  reg fault_reg, selftest_fail_reg, saving_reg, saved_reg, pwr_d_reg;
  reg [`BCS_IRQ_W-1:0] istat_reg, imask_reg, ev;
  reg [31:0] save_data_reg;
  reg charge_req_reg;
  wire signed [15:0] tb;
  wire too_hot, too_cold, is_hot, is_cold, bad_bat;
  wire [`BCS_SEC_W-1:0] limit_s;
  wire wr, rd, acc_ok;
  integer i;

  bcs_tick u_tick (
    .clk(clk),
    .srst(srst),
    .sec_pulse(sec_pulse)
  );

  // pins cross into clk domain; only stage two is read
  always @(posedge clk) begin
    if (srst) begin
      mv_s1_reg <= 16'h0000;
      mv_s2_reg <= 16'h0000;
      ma_s1_reg <= 16'h0000;
      ma_s2_reg <= 16'h0000;
      tc_s1_reg <= 16'h0000;
      tc_s2_reg <= 16'h0000;
      pres_s_reg <= 2'h0;
      pwr_s_reg <= 2'h3; // power-up means main power is present, no false loss edge
      fill_reg <= 2'h0;
    end else begin
      mv_s1_reg <= bat_mv;
      mv_s2_reg <= mv_s1_reg;
      ma_s1_reg <= chg_ma;
      ma_s2_reg <= ma_s1_reg;
      tc_s1_reg <= cpu_temp;
      tc_s2_reg <= tc_s1_reg;
      pres_s_reg <= {pres_s_reg[0], bat_present};
      pwr_s_reg <= {pwr_s_reg[0], main_power_ok};
      // fill marks when stage two holds real pin samples
      fill_reg <= {fill_reg[0], 1'b1};
    end
  end

  // battery temperature and band decode; multi-bit words assumed steady between samples
  assign tb = $signed(tc_s2_reg) - $signed(`BCS_T_OFFSET);
  assign too_hot = tb > $signed(`BCS_T_HOT_MAX);
  assign too_cold = tb < $signed(16'h0000);
  assign is_hot = tb > $signed(`BCS_T_NORM_MAX);
  assign is_cold = tb <= $signed(`BCS_T_COLD_MAX);
  // no battery verdict until the synchronisers hold real samples, else reset zeros look like a fault
  assign bad_bat = fill_reg[1] && (!pres_s_reg[1] || (mv_s2_reg < `BCS_MV_MIN));
  // fast mode 8 h, slow modes 40 h
  assign limit_s = (state_reg == `BCS_ST_NORMAL) ? `BCS_NORM_LIMIT_S : `BCS_SLOW_LIMIT_S;

  // next state: a temperature band change moves between modes
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `BCS_ST_WAIT: begin
        if (bad_bat)
          state_next = pres_s_reg[1] ? `BCS_ST_LOWV : `BCS_ST_NOBAT;
        else if (sec_pulse && secs_reg >= `BCS_WAIT_S - 1'b1)
          state_next = `BCS_ST_NORMAL;
      end
      `BCS_ST_NORMAL, `BCS_ST_HOT, `BCS_ST_COLD, `BCS_ST_TOOHOT, `BCS_ST_TOOCOLD: begin
        if (bad_bat)
          state_next = pres_s_reg[1] ? `BCS_ST_LOWV : `BCS_ST_NOBAT;
        else if (too_hot)
          state_next = `BCS_ST_TOOHOT;
        else if (too_cold)
          state_next = `BCS_ST_TOOCOLD;
        else if (is_hot && state_reg != `BCS_ST_HOT)
          state_next = `BCS_ST_HOT;
        else if (is_cold && !is_hot && state_reg != `BCS_ST_COLD)
          state_next = `BCS_ST_COLD;
        else if (!is_hot && !is_cold && state_reg != `BCS_ST_NORMAL)
          state_next = `BCS_ST_NORMAL;
        else if (state_reg == `BCS_ST_HOT && mv_s2_reg >= `BCS_MV_FULL_LO)
          state_next = `BCS_ST_FULL41;
        else if (state_reg != `BCS_ST_HOT && mv_s2_reg >= `BCS_MV_FULL_HI)
          state_next = `BCS_ST_FULL42;
        else if (sec_pulse && secs_reg >= limit_s - 1'b1)
          state_next = `BCS_ST_NOCHG;
      end
      `BCS_ST_NOCHG: begin
        if (sec_pulse && secs_reg >= `BCS_PAUSE_S - 1'b1)
          state_next = `BCS_ST_NORMAL;
      end
      `BCS_ST_FULL42: state_next = `BCS_ST_WAITDIS;
      `BCS_ST_WAITDIS: begin
        if (mv_s2_reg < `BCS_MV_RECHG)
          state_next = `BCS_ST_NORMAL;
      end
      // holding 4.1V still obeys the battery and temperature limits
      `BCS_ST_FULL41: begin
        if (bad_bat)
          state_next = pres_s_reg[1] ? `BCS_ST_LOWV : `BCS_ST_NOBAT;
        else if (too_hot)
          state_next = `BCS_ST_TOOHOT;
        else if (too_cold)
          state_next = `BCS_ST_TOOCOLD;
        else if (!is_hot)
          state_next = `BCS_ST_NORMAL;
      end
      `BCS_ST_NOBAT, `BCS_ST_LOWV: state_next = state_reg;
      default: state_next = `BCS_ST_WAIT;
    endcase
  end

  // state and timer; reset is power-up and always restarts waiting
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= `BCS_ST_WAIT;
      secs_reg <= {`BCS_SEC_W{1'b0}};
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg)
        secs_reg <= {`BCS_SEC_W{1'b0}};
      else if (sec_pulse)
        secs_reg <= secs_reg + 1'b1;
    end
  end

  // charger drive from state, registered
  always @(posedge clk) begin
    if (srst) begin
      charge_en <= 1'b0;
      target_4v1 <= 1'b0;
      charge_ma_set <= 16'h0000;
      charge_req_reg <= 1'b0;
    end else begin
      charge_req_reg <= (state_next == `BCS_ST_NORMAL) || (state_next == `BCS_ST_HOT) ||
                        (state_next == `BCS_ST_COLD) || (state_next == `BCS_ST_FULL41);
      charge_en <= charge_req_reg;
      target_4v1 <= (state_reg == `BCS_ST_HOT) || (state_reg == `BCS_ST_FULL41);
      charge_ma_set <= (state_reg == `BCS_ST_NORMAL) ? `BCS_I_FAST : `BCS_I_SLOW;
    end
  end

  // fault flag and self-test result, sticky until power-up
  always @(posedge clk) begin
    if (srst) begin
      fault_reg <= 1'b0;
      selftest_fail_reg <= 1'b0;
    end else if (state_reg == `BCS_ST_NOBAT || state_reg == `BCS_ST_LOWV) begin
      fault_reg <= 1'b1;
      selftest_fail_reg <= 1'b1;
    end
  end

  // power loss: run a 100 ms save window, millisecond counter
  always @(posedge clk) begin
    if (srst) begin
      pwr_d_reg <= 1'b1;
      saving_reg <= 1'b0;
      saved_reg <= 1'b0;
      ms_reg <= {`BCS_SEC_W{1'b0}};
      mscyc_reg <= 18'h00000;
      save_to_flash <= 1'b0;
      ram_retain <= 1'b1;
    end else begin
      pwr_d_reg <= pwr_s_reg[1];
      ram_retain <= pwr_s_reg[1];
      save_to_flash <= saving_reg;
      if (pwr_d_reg && !pwr_s_reg[1]) begin
        saving_reg <= 1'b1;
        saved_reg <= 1'b0;
        ms_reg <= {`BCS_SEC_W{1'b0}};
        mscyc_reg <= 18'h00000;
      end else if (saving_reg) begin
        if (mscyc_reg == `BCS_MS_CYC - 1'b1) begin
          mscyc_reg <= 18'h00000;
          ms_reg <= ms_reg + 1'b1;
        end else
          mscyc_reg <= mscyc_reg + 1'b1;
        if (ms_reg == `BCS_SAVE_MS - 1'b1 && mscyc_reg == `BCS_MS_CYC - 1'b1) begin
          saving_reg <= 1'b0;
          saved_reg <= 1'b1;
        end
      end
    end
  end

  // interrupt events
  always @* begin
    ev = {`BCS_IRQ_W{1'b0}};
    ev[`BCS_I_STATE] = state_next != state_reg;
    // fault counts on entry only, so a held fault state can still be cleared
    ev[`BCS_I_FAULT] = ((state_next == `BCS_ST_NOBAT) || (state_next == `BCS_ST_LOWV)) && state_next != state_reg;
    ev[`BCS_I_FULL] = (state_next == `BCS_ST_FULL42 || state_next == `BCS_ST_FULL41) && state_next != state_reg;
    ev[`BCS_I_SAVED] = saving_reg && !pwr_s_reg[1] && ms_reg == `BCS_SAVE_MS - 1'b1 &&
                       mscyc_reg == `BCS_MS_CYC - 1'b1;
  end

  // apb: zero wait states, unmapped reads zero with error
  // pready tied high: every access completes in its first access cycle
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign acc_ok = paddr <= `BCS_A_SAVE && paddr[1:0] == 2'b00;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !acc_ok;
  assign irq = |(istat_reg & imask_reg);

  // write one to clear; a new event wins over the clear
  always @(posedge clk) begin
    if (srst) begin
      istat_reg <= {`BCS_IRQ_W{1'b0}};
      imask_reg <= {`BCS_IRQ_W{1'b0}};
      save_data_reg <= 32'h00000000;
    end else begin
      for (i = 0; i < `BCS_IRQ_W; i = i + 1) begin
        if (ev[i])
          istat_reg[i] <= 1'b1;
        else if (wr && paddr == `BCS_A_ISTAT && pwdata[i])
          istat_reg[i] <= 1'b0;
      end
      if (wr && paddr == `BCS_A_IMASK)
        imask_reg <= pwdata[`BCS_IRQ_W-1:0];
      if (wr && paddr == `BCS_A_SAVE)
        save_data_reg <= pwdata;
    end
  end

  // read data registered in the setup cycle
  always @(posedge clk) begin
    if (srst)
      prdata <= 32'h00000000;
    else if (rd && !penable) begin
      case (paddr)
        `BCS_A_STATE: prdata <= {28'h0000000, state_reg};
        `BCS_A_TEMP: prdata <= {16'h0000, tc_s2_reg};
        `BCS_A_VOLT: prdata <= {16'h0000, mv_s2_reg};
        `BCS_A_CURR: prdata <= {16'h0000, ma_s2_reg};
        `BCS_A_FLAGS: prdata <= {28'h0000000, saved_reg, saving_reg, selftest_fail_reg, fault_reg};
        `BCS_A_CTRL: prdata <= {16'h0000, charge_ma_set};
        `BCS_A_ISTAT: prdata <= {28'h0000000, istat_reg};
        `BCS_A_IMASK: prdata <= {28'h0000000, imask_reg};
        `BCS_A_SAVE: prdata <= save_data_reg;
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // bcs_seq

//--- verilog/bcs_tick.v
// one-second enable pulse divider for the charge sequencer timers
// assumes clk at the rate of BCS_CLK_HZ
`timescale 1ns/1ps
`include "bcs_consts.vh"
module bcs_tick (
  // clock and reset
  input wire clk,
  input wire srst,
  // one cycle pulse every second
  output reg sec_pulse
);
  reg [`BCS_TICK_W-1:0] cnt_reg;

  // free running divider, restarts with reset
  always @(posedge clk) begin
    if (srst) begin
      cnt_reg <= {`BCS_TICK_W{1'b0}};
      sec_pulse <= 1'b0;
    end else if (cnt_reg == `BCS_TICK_CYC) begin
      cnt_reg <= {`BCS_TICK_W{1'b0}};
      sec_pulse <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      sec_pulse <= 1'b0;
    end
  end
endmodule // bcs_tick
